// File: logic/cond_decode_regs.vh
/*
 * Constants for the conditional execution and opcode field decoder:
 * instruction type codes, field encodings and the instruction type width.
 * Assumes inclusion by bare name from the decoder file.
 */
`ifndef COND_DECODE_REGS_VH
`define COND_DECODE_REGS_VH

// ----------------------------------------------------------------
// Instruction types that carry an if-ELSE compute
// ----------------------------------------------------------------
`define ITYPE_W            4
`define ITYPE_IND_BRANCH   4'h9
`define ITYPE_IND_MEM      4'hA
`define ITYPE_RETURN       4'hB

// ----------------------------------------------------------------
// Bit operation encodings
// ----------------------------------------------------------------
`define BITOP_SET          3'h0
`define BITOP_CLR          3'h1
`define BITOP_TGL          3'h2
`define BITOP_TST          3'h4
`define BITOP_XOR          3'h5

// ----------------------------------------------------------------
// Cache register select encodings
// ----------------------------------------------------------------
`define CACHE_SEL_LO       2'h0
`define CACHE_SEL_HI       2'h1
`define CACHE_SEL_CAM      2'h3

// ----------------------------------------------------------------
// Computation unit encodings
// ----------------------------------------------------------------
`define CU_ALU             2'h0
`define CU_MUL             2'h1
`define CU_SHF             2'h2

// ----------------------------------------------------------------
// Second address generator register offset
// ----------------------------------------------------------------
`define AGEN2_BASE         4'h8

`endif

// File: logic/simd_cond_exec_field_decode.v
/*
 * Decoder for conditional execution in single and dual element modes,
 * and for the opcode control fields of the instruction word.
 * Assumes fields are presented already extracted by the sequencer on
 * the core clock; condition results come from same-clock logic.
 */
// How it works
// RULE_01: Dual mode: each element gates by own condition
// RULE_02: Dual mode: jump/call needs both conditions true
// RULE_03: Dual mode ELSE: element uses inverted own condition
// RULE_04: Single mode return: test alone decides return, test/ELSE decide compute
// RULE_05: Dual mode return only when both tests true
// RULE_06: Dual compute runs when test differs from ELSE
// RULE_07: ELSE honoured only in types 9, 10, 11
// RULE_08: Unassigned opcode bits never affect behaviour
// RULE_09: Loop abort pops loop and PC stacks
// RULE_10: Bit operation select decoded to five operations
// RULE_11: Clear-interrupt field clears current interrupt
// RULE_12: Cache select: low, high, or CAM entry
// RULE_13: Unit select: ALU, multiplier, shifter
// RULE_14: Agen1 registers 0-7, agen2 index 8-15
// RULE_15: Memory select picks generator and memory
// RULE_16: Long-word field forces 64-bit access
// RULE_17: Loop stack push/pop act only when set
// RULE_18: Single mode uses primary element only
`timescale 1ns/10ps
`include "cond_decode_regs.vh"

module simd_cond_exec_field_decode (
	input  wire                core_clk_i,
	input  wire                rst_i,
	input  wire                clk_en_i,
	input  wire                instr_valid_i,
	input  wire                simd_mode_i,
	input  wire [3:0]          instr_type_i,
	input  wire                is_compute_i,
	input  wire                is_branch_i,
	input  wire                is_return_i,
	input  wire                else_field_i,
	input  wire                cond_x_i,
	input  wire                cond_y_i,
	input  wire                loop_abort_field_i,
	input  wire [2:0]          bitop_select_field_i,
	input  wire                clear_current_irq_field_i,
	input  wire [1:0]          cache_reg_select_i,
	input  wire [1:0]          compute_unit_select_i,
	input  wire [2:0]          agen1_index_number_i,
	input  wire [2:0]          agen1_modify_number_i,
	input  wire [2:0]          agen2_index_number_i,
	input  wire                mem_select_field_i,
	input  wire                long_word_field_i,
	input  wire                loop_stack_push_field_i,
	input  wire                loop_stack_pop_field_i,
	output reg                 compute_en_x_o,
	output reg                 compute_en_y_o,
	output reg                 branch_take_o,
	output reg                 return_take_o,
	output reg                 pop_loop_pc_stacks_o,
	output reg                 bitop_set_o,
	output reg                 bitop_clr_o,
	output reg                 bitop_tgl_o,
	output reg                 bitop_tst_o,
	output reg                 bitop_xor_o,
	output reg                 bitop_undef_o,
	output reg                 clear_irq_o,
	output reg                 cache_lo_sel_o,
	output reg                 cache_hi_sel_o,
	output reg                 cache_cam_sel_o,
	output reg                 alu_sel_o,
	output reg                 mul_sel_o,
	output reg                 shf_sel_o,
	output reg [3:0]           agen1_index_reg_o,
	output reg [3:0]           agen1_modify_reg_o,
	output reg [3:0]           agen2_index_reg_o,
	output reg                 first_address_generator_sel_o,
	output reg                 second_address_generator_sel_o,
	output reg                 long_word_access_o,
	output reg                 loop_stack_push_o,
	output reg                 loop_stack_pop_o
);

// ----------------------------------------------------------------
// Conditional execution
// ----------------------------------------------------------------
wire        else_ok;
wire        else_eff;
wire        run_x;
wire        run_y;
wire        both_true;
wire        br_cond;

assign else_ok   = (instr_type_i == `ITYPE_IND_BRANCH) |
                   (instr_type_i == `ITYPE_IND_MEM) |
                   (instr_type_i == `ITYPE_RETURN); // RULE_07
assign else_eff  = else_field_i & else_ok; // RULE_07
// Compute runs when the local test differs from the effective ELSE bit (else_eff); y runs only in dual mode
assign run_x     = cond_x_i ^ else_eff; // RULE_01 RULE_03 RULE_04 RULE_06
assign run_y     = (cond_y_i ^ else_eff) & simd_mode_i; // RULE_06 RULE_18
assign both_true = cond_x_i & cond_y_i; // RULE_02 RULE_05
assign br_cond   = simd_mode_i ? both_true : cond_x_i; // RULE_18

wire        go;
assign go = instr_valid_i;

// ----------------------------------------------------------------
// Next values
// ----------------------------------------------------------------
reg         compute_en_x_next;
reg         compute_en_y_next;
reg         branch_take_next;
reg         return_take_next;
reg         pop_loop_pc_stacks_next;
reg         bitop_set_next;
reg         bitop_clr_next;
reg         bitop_tgl_next;
reg         bitop_tst_next;
reg         bitop_xor_next;
reg         bitop_undef_next;
reg         clear_irq_next;
reg         cache_lo_sel_next;
reg         cache_hi_sel_next;
reg         cache_cam_sel_next;
reg         alu_sel_next;
reg         mul_sel_next;
reg         shf_sel_next;
reg  [3:0]  agen1_index_reg_next;
reg  [3:0]  agen1_modify_reg_next;
reg  [3:0]  agen2_index_reg_next;
reg         first_address_generator_sel_next;
reg         second_address_generator_sel_next;
reg         long_word_access_next;
reg         loop_stack_push_next;
reg         loop_stack_pop_next;

// ----------------------------------------------------------------
// Conditional outcome decode
// ----------------------------------------------------------------
always @* begin
	compute_en_x_next       = 1'h0;
	compute_en_y_next       = 1'h0;
	branch_take_next        = 1'h0;
	return_take_next        = 1'h0;
	pop_loop_pc_stacks_next = 1'h0;
	if (go) begin
		compute_en_x_next = is_compute_i & run_x; // RULE_01 RULE_03
		compute_en_y_next = is_compute_i & run_y; // RULE_01 RULE_18
		branch_take_next  = is_branch_i & br_cond; // RULE_02
		return_take_next  = is_return_i & br_cond; // RULE_04 RULE_05
		pop_loop_pc_stacks_next = is_branch_i & br_cond &
		                          loop_abort_field_i; // RULE_09
	end
end

// ----------------------------------------------------------------
// Bit operation decode
// ----------------------------------------------------------------
always @* begin
	bitop_set_next   = 1'h0;
	bitop_clr_next   = 1'h0;
	bitop_tgl_next   = 1'h0;
	bitop_tst_next   = 1'h0;
	bitop_xor_next   = 1'h0;
	bitop_undef_next = 1'h0;
	if (go) begin
		case (bitop_select_field_i)
		`BITOP_SET: begin
			bitop_set_next = 1'h1; // RULE_10
		end
		`BITOP_CLR: begin
			bitop_clr_next = 1'h1; // RULE_10
		end
		`BITOP_TGL: begin
			bitop_tgl_next = 1'h1; // RULE_10
		end
		`BITOP_TST: begin
			bitop_tst_next = 1'h1; // RULE_10
		end
		`BITOP_XOR: begin
			bitop_xor_next = 1'h1; // RULE_10
		end
		default: begin
			bitop_undef_next = 1'h1;
		end
		endcase
	end
end

// ----------------------------------------------------------------
// Cache register and computation unit decode
// ----------------------------------------------------------------
always @* begin
	cache_lo_sel_next  = 1'h0;
	cache_hi_sel_next  = 1'h0;
	cache_cam_sel_next = 1'h0;
	alu_sel_next       = 1'h0;
	mul_sel_next       = 1'h0;
	shf_sel_next       = 1'h0;
	if (go) begin
		case (cache_reg_select_i)
		`CACHE_SEL_LO: begin
			cache_lo_sel_next = 1'h1; // RULE_12
		end
		`CACHE_SEL_HI: begin
			cache_hi_sel_next = 1'h1; // RULE_12
		end
		`CACHE_SEL_CAM: begin
			cache_cam_sel_next = 1'h1; // RULE_12
		end
		default: begin
			cache_lo_sel_next = 1'h0;
		end
		endcase
		case (compute_unit_select_i)
		`CU_ALU: begin
			alu_sel_next = 1'h1; // RULE_13
		end
		`CU_MUL: begin
			mul_sel_next = 1'h1; // RULE_13
		end
		`CU_SHF: begin
			shf_sel_next = 1'h1; // RULE_13
		end
		default: begin
			alu_sel_next = 1'h0;
		end
		endcase
	end
end

// ----------------------------------------------------------------
// Address generator and memory decode
// ----------------------------------------------------------------
always @* begin
	agen1_index_reg_next  = {1'h0, agen1_index_number_i}; // RULE_14
	agen1_modify_reg_next = {1'h0, agen1_modify_number_i}; // RULE_14
	agen2_index_reg_next  = `AGEN2_BASE |
	                        {1'h0, agen2_index_number_i}; // RULE_14
	first_address_generator_sel_next  = 1'h0;
	second_address_generator_sel_next = 1'h0;
	long_word_access_next             = 1'h0;
	if (go) begin
		first_address_generator_sel_next  =
			~mem_select_field_i; // RULE_15
		second_address_generator_sel_next =
			mem_select_field_i; // RULE_15
		long_word_access_next = long_word_field_i; // RULE_16
	end
end

// ----------------------------------------------------------------
// Interrupt clear and loop stack decode
// ----------------------------------------------------------------
always @* begin
	clear_irq_next       = 1'h0;
	loop_stack_push_next = 1'h0;
	loop_stack_pop_next  = 1'h0;
	if (go) begin
		clear_irq_next       = clear_current_irq_field_i; // RULE_11
		loop_stack_push_next = loop_stack_push_field_i; // RULE_17
		loop_stack_pop_next  = loop_stack_pop_field_i; // RULE_17
	end
end

// ----------------------------------------------------------------
// Conditional outcome flops
// ----------------------------------------------------------------
always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		compute_en_x_o       <= 1'h0;
		compute_en_y_o       <= 1'h0;
		branch_take_o        <= 1'h0;
		return_take_o        <= 1'h0;
		pop_loop_pc_stacks_o <= 1'h0;
	end else if (clk_en_i) begin
		compute_en_x_o       <= compute_en_x_next;
		compute_en_y_o       <= compute_en_y_next;
		branch_take_o        <= branch_take_next;
		return_take_o        <= return_take_next;
		pop_loop_pc_stacks_o <= pop_loop_pc_stacks_next;
	end
end

// ----------------------------------------------------------------
// Bit operation flops
// ----------------------------------------------------------------
always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		bitop_set_o   <= 1'h0;
		bitop_clr_o   <= 1'h0;
		bitop_tgl_o   <= 1'h0;
		bitop_tst_o   <= 1'h0;
		bitop_xor_o   <= 1'h0;
		bitop_undef_o <= 1'h0;
	end else if (clk_en_i) begin
		bitop_set_o   <= bitop_set_next;
		bitop_clr_o   <= bitop_clr_next;
		bitop_tgl_o   <= bitop_tgl_next;
		bitop_tst_o   <= bitop_tst_next;
		bitop_xor_o   <= bitop_xor_next;
		bitop_undef_o <= bitop_undef_next;
	end
end

// ----------------------------------------------------------------
// Cache register and computation unit flops
// ----------------------------------------------------------------
always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		cache_lo_sel_o  <= 1'h0;
		cache_hi_sel_o  <= 1'h0;
		cache_cam_sel_o <= 1'h0;
		alu_sel_o       <= 1'h0;
		mul_sel_o       <= 1'h0;
		shf_sel_o       <= 1'h0;
	end else if (clk_en_i) begin
		cache_lo_sel_o  <= cache_lo_sel_next;
		cache_hi_sel_o  <= cache_hi_sel_next;
		cache_cam_sel_o <= cache_cam_sel_next;
		alu_sel_o       <= alu_sel_next;
		mul_sel_o       <= mul_sel_next;
		shf_sel_o       <= shf_sel_next;
	end
end

// ----------------------------------------------------------------
// Address, memory, interrupt and loop stack flops
// ----------------------------------------------------------------
always @(posedge core_clk_i or posedge rst_i) begin
	if (rst_i) begin
		agen1_index_reg_o              <= 4'h0;
		agen1_modify_reg_o             <= 4'h0;
		agen2_index_reg_o              <= `AGEN2_BASE;
		first_address_generator_sel_o  <= 1'h0;
		second_address_generator_sel_o <= 1'h0;
		long_word_access_o             <= 1'h0;
		clear_irq_o                    <= 1'h0;
		loop_stack_push_o              <= 1'h0;
		loop_stack_pop_o               <= 1'h0;
	end else if (clk_en_i) begin
		agen1_index_reg_o  <= agen1_index_reg_next;
		agen1_modify_reg_o <= agen1_modify_reg_next;
		agen2_index_reg_o  <= agen2_index_reg_next;
		first_address_generator_sel_o  <=
			first_address_generator_sel_next;
		second_address_generator_sel_o <=
			second_address_generator_sel_next;
		long_word_access_o <= long_word_access_next;
		clear_irq_o        <= clear_irq_next;
		loop_stack_push_o  <= loop_stack_push_next;
		loop_stack_pop_o   <= loop_stack_pop_next;
	end
end

// Only named field inputs exist; reserved opcode bits have no port
// and so cannot alter any output. RULE_08

endmodule

// File: test/cond_flag_model.sv
/* Condition flag source for the primary and secondary elements.
   Assumes the bench sets the wanted flags just after a clock edge. */
`timescale 1ns/10ps
module cond_flag_model (
	input  wire want_x_i,
	input  wire want_y_i,
	output wire cond_x_o,
	output wire cond_y_o
);
	// Flags move only when the bench asks for a new result
	assign cond_x_o = want_x_i;
	assign cond_y_o = want_y_i;
endmodule

// File: test/simd_cond_exec_field_decode_chk.sv
/* Concurrent checks on the decoder outputs.
   Assumes binding into the decoder, seeing its ports only. */
`timescale 1ns/10ps
module simd_cond_exec_field_decode_chk (
	input wire       core_clk_i, rst_i, clk_en_i, instr_valid_i,
	input wire       simd_mode_i, is_compute_i, is_branch_i, is_return_i,
	input wire       else_field_i, cond_x_i, cond_y_i, loop_abort_field_i,
	input wire       clear_current_irq_field_i, compute_en_x_o,
	input wire       compute_en_y_o, branch_take_o, return_take_o,
	input wire       pop_loop_pc_stacks_o, bitop_xor_o, clear_irq_o,
	input wire       cache_cam_sel_o, shf_sel_o,
	input wire [3:0] instr_type_i, agen2_index_reg_o,
	input wire [2:0] bitop_select_field_i, agen2_index_number_i,
	input wire [1:0] cache_reg_select_i, compute_unit_select_i
);
	wire ee = else_field_i && instr_type_i >= 4'h9 && instr_type_i <= 4'hB;
	wire go = clk_en_i && instr_valid_i;
	wire both = cond_x_i && (cond_y_i || !simd_mode_i);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_go(c); go && c; endsequence
	a_comp_x_own: assert property (clk_en_i |=> compute_en_x_o ==
		$past(instr_valid_i && is_compute_i && (cond_x_i ^ ee))) else $error("x compute");
	a_comp_y_own: assert property (clk_en_i |=> compute_en_y_o ==
		$past(go && is_compute_i && simd_mode_i && (cond_y_i ^ ee))) else $error("y compute");
	a_branch_and: assert property (clk_en_i |=> branch_take_o ==
		$past(go && is_branch_i && both)) else $error("branch");
	a_return_both: assert property (s_go(is_return_i && both) |=> return_take_o)
		else $error("return missed");
	a_return_nop: assert property (s_go(is_return_i && !both) |=> !return_take_o)
		else $error("return spurious");
	a_loop_abort: assert property (clk_en_i |=> pop_loop_pc_stacks_o ==
		$past(go && is_branch_i && both && loop_abort_field_i)) else $error("abort");
	a_bitop_xor: assert property (s_go(bitop_select_field_i == 3'h5) |=> bitop_xor_o)
		else $error("xor");
	a_clear_irq: assert property (clk_en_i |=> clear_irq_o ==
		$past(go && clear_current_irq_field_i)) else $error("clear irq");
	a_cache_cam: assert property (s_go(cache_reg_select_i == 2'h3) |=> cache_cam_sel_o)
		else $error("cam");
	a_unit_shf: assert property (s_go(compute_unit_select_i == 2'h2) |=> shf_sel_o)
		else $error("shifter");
	a_agen2_range: assert property (clk_en_i |=> agen2_index_reg_o ==
		{1'h1, $past(agen2_index_number_i)}) else $error("agen2");
	a_hold_frozen: assert property (!clk_en_i |=>
		$stable({compute_en_x_o, branch_take_o, agen2_index_reg_o})) else $error("freeze");
endmodule

// File: test/simd_cond_exec_field_decode_bench.sv
/* Self-checking bench for the conditional execution decoder.
   Assumes the flag model and the checker are compiled first. */
`timescale 1ns/10ps
module simd_cond_exec_field_decode_bench;
	logic core_clk_i = 0, rst_i = 1, clk_en_i = 1, instr_valid_i = 0;
	logic simd_mode_i = 0, is_compute_i = 0, is_branch_i = 0, want_x = 0;
	logic is_return_i = 0, else_field_i = 0, loop_abort_field_i = 0;
	logic clear_current_irq_field_i = 0, mem_select_field_i = 0, want_y = 0;
	logic long_word_field_i = 0, loop_stack_push_field_i = 0;
	logic loop_stack_pop_field_i = 0;
	logic [3:0] instr_type_i = 4'hB;
	logic [2:0] bitop_select_field_i = 0, agen1_index_number_i = 0;
	logic [2:0] agen1_modify_number_i = 0, agen2_index_number_i = 0;
	logic [1:0] cache_reg_select_i = 0, compute_unit_select_i = 0;
	wire cond_x_i, cond_y_i, compute_en_x_o, compute_en_y_o, branch_take_o;
	wire return_take_o, pop_loop_pc_stacks_o, bitop_set_o, bitop_clr_o;
	wire bitop_tgl_o, bitop_tst_o, bitop_xor_o, bitop_undef_o, clear_irq_o;
	wire cache_lo_sel_o, cache_hi_sel_o, cache_cam_sel_o, alu_sel_o;
	wire mul_sel_o, shf_sel_o, first_address_generator_sel_o;
	wire second_address_generator_sel_o, long_word_access_o;
	wire loop_stack_push_o, loop_stack_pop_o;
	wire [3:0] agen1_index_reg_o, agen1_modify_reg_o, agen2_index_reg_o;
	int mismatches = 0, comparisons = 0;
	cond_flag_model i_flags (.want_x_i(want_x), .want_y_i(want_y),
		.cond_x_o(cond_x_i), .cond_y_o(cond_y_i));
	simd_cond_exec_field_decode i_dut (.*);
	initial forever #25 core_clk_i = ~core_clk_i;
	task cyc; @(posedge core_clk_i); #2; endtask
	task cmp(input string n, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task t_cond_table;
		for (int i = 0; i < 16; i++) begin
			{simd_mode_i, want_x, want_y, else_field_i} = i[3:0];
			cyc;
			cmp("cx", i[2] ^ i[0], compute_en_x_o);
			cmp("cy", i[3] & (i[1] ^ i[0]), compute_en_y_o);
			cmp("rt", i[2] & (i[1] | ~i[3]), return_take_o);
			cmp("br", i[2] & (i[1] | ~i[3]), branch_take_o);
		end
	endtask
	task t_else_type;
		{simd_mode_i, want_x, want_y, else_field_i} = 4'h7;
		for (int i = 8; i < 13; i++) begin
			instr_type_i = i[3:0];
			cyc;
			cmp("ty", i < 9 || i > 11, compute_en_x_o);
		end
	endtask
	task t_fields;
		logic [2:0] k;
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			{bitop_select_field_i, agen1_index_number_i} = {k, k};
			{agen2_index_number_i, agen1_modify_number_i} = {k, ~k};
			{cache_reg_select_i, compute_unit_select_i} = {k[1:0], k[1:0]};
			{mem_select_field_i, long_word_field_i} = k[1:0];
			{loop_stack_push_field_i, loop_stack_pop_field_i} = k[1:0];
			{clear_current_irq_field_i, loop_abort_field_i} = {k[2], k[0]};
			cyc;
			cmp("bop", {k == 0, k == 1, k == 2, k == 4, k == 5, k == 3 || k > 5},
				{bitop_set_o, bitop_clr_o, bitop_tgl_o, bitop_tst_o,
				bitop_xor_o, bitop_undef_o});
			cmp("sel", {k[1:0] == 0, k[1:0] == 1, k[1:0] == 3, k[1:0] == 0,
				k[1:0] == 1, k[1:0] == 2}, {cache_lo_sel_o, cache_hi_sel_o,
				cache_cam_sel_o, alu_sel_o, mul_sel_o, shf_sel_o});
			cmp("reg", {1'h0, k, 1'h0, ~k, 1'h1, k}, {agen1_index_reg_o,
				agen1_modify_reg_o, agen2_index_reg_o});
			cmp("mis", {~k[1], k[1], k[0], k[1], k[0], k[2], k[0]},
				{first_address_generator_sel_o, second_address_generator_sel_o,
				long_word_access_o, loop_stack_push_o, loop_stack_pop_o,
				clear_irq_o, pop_loop_pc_stacks_o});
		end
	endtask
	task t_freeze;
		{simd_mode_i, want_x, want_y, else_field_i} = 4'h4;
		cyc;
		cmp("fz", 1, compute_en_x_o);
		{clk_en_i, instr_valid_i} = 2'h0;
		cyc;
		cmp("fz", 1, compute_en_x_o);
		clk_en_i = 1;
		cyc;
		cmp("fz", 0, compute_en_x_o);
	endtask
	initial begin
		repeat (6) @(posedge core_clk_i);
		#2;
		cmp("rst", 16'h0008, {compute_en_x_o, agen2_index_reg_o});
		rst_i = 0;
		{instr_valid_i, is_compute_i, is_return_i, is_branch_i} = 4'hF;
		t_cond_table;
		t_else_type;
		t_fields;
		t_freeze;
		stop_test;
	end
	initial begin
		#100000;
		mismatches++;
		stop_test;
	end
endmodule
bind simd_cond_exec_field_decode simd_cond_exec_field_decode_chk i_chk (.*);
